// *** pmsc_map.svh ***
// register offsets, field positions and reset values of the power manager
`ifndef PMSC_MAP_SVH
`define PMSC_MAP_SVH

`define PMSC_ADDR_W 3
`define PMSC_DATA_W 8
`define PMSC_IRQ_W 3

`define PMSC_OFS_CTRL1 3'h0
`define PMSC_OFS_CTRL2 3'h1
`define PMSC_OFS_IRQ_STAT 3'h2
`define PMSC_OFS_IRQ_CLR 3'h3
`define PMSC_OFS_IRQ_EN 3'h4

`define PMSC_C1_DET_FLAG 7
`define PMSC_C1_DET_ACK 6
`define PMSC_C1_DET_IRQ_EN 5
`define PMSC_C1_SAFE_STATE 4
`define PMSC_C1_DET_RST_EN 3

`define PMSC_C2_WARN_FLAG 7
`define PMSC_C2_WARN_ACK 6
`define PMSC_C2_PPD_FLAG 3
`define PMSC_C2_PPD_ACK 2
`define PMSC_C2_PD_EN 1
`define PMSC_C2_PPD_SEL 0

`define PMSC_IRQ_DET 0
`define PMSC_IRQ_WARN 1
`define PMSC_IRQ_PPD 2

`define PMSC_RST_DET_RST_EN 1'b1
`define PMSC_RST_BIT 1'b0
`define PMSC_RST_BYTE 8'h00
`define PMSC_RST_IRQ 3'h0

`endif

// *** pmsc_pkg.sv ***
// types shared by the power management status and control block
`include "pmsc_map.svh"

package pmsc_pkg;

    typedef logic [`PMSC_ADDR_W-1:0] pmsc_addr_t;
    typedef logic [`PMSC_DATA_W-1:0] pmsc_byte_t;
    typedef logic [`PMSC_IRQ_W-1:0] pmsc_irq_t;

    typedef struct packed {
        logic det_s1;
        logic det_s2;
        logic warn_s1;
        logic warn_s2;
        logic rearm_s1;
        logic rearm_s2;
        logic ppd_s1;
        logic ppd_s2;
        logic ppd_s3;
        logic low_volt_detect_flag;
        logic low_volt_detect_irq_en;
        logic safe_state;
        logic low_volt_detect_reset_en;
        logic det_rst_en_locked;
        logic low_volt_warning_flag;
        logic partial_powerdown_flag;
        logic powerdown_enable;
        logic partial_powerdown_select;
        logic pd_locked;
        pmsc_irq_t irq_stat;
        pmsc_irq_t irq_en;
        pmsc_byte_t rdata;
        logic irq;
        logic det_irq_req;
        logic det_rst_req;
        logic wake_block;
    } pmsc_state_s;

endpackage

// *** pmsc_top.sv ***
// power management status and control: low-voltage flags and stop modes
//
// Notes on behaviour
// - detect flag sets on event while detect enabled
// - detect ack write one clears; reads zero
// - detect irq enable requests irq while flag
// - safe state blocks wakeups below rearm level
// - detect reset enable accepts first write only; sys_reset here clears the lock, so one more write is taken
// - power-on sets detect reset enable; others keep
// - detect reset enable forces reset on flag
// - warning flag sets below trip, sticks
// - warning ack clears only once condition gone
// - partial power-down flag set on its recovery
// - partial power-down ack write one clears
// - power-down enable write-once; gates both modes
// - partial select write-once; picks stop flavour
//
// The implementer's own choices: the strobed register port and the register offsets.
`include "pmsc_map.svh"
`timescale 1ns/1ns
`default_nettype none

module pmsc_top
    import pmsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sys_reset,
    input wire logic low_volt_detect_en,
    input wire logic det_trip,
    input wire logic warn_trip,
    input wire logic below_rearm,
    input wire logic ppd_recovered,
    input wire logic [`PMSC_ADDR_W-1:0] addr,
    input wire logic [`PMSC_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`PMSC_DATA_W-1:0] rdata,
    output logic irq,
    output logic det_irq_req,
    output logic det_rst_req,
    output logic wake_block,
    output logic powerdown_enable,
    output logic partial_powerdown_select
);

    // rst is the power-on reset; sys_reset stands for every other source
    localparam pmsc_state_s ST_RST = '{
        low_volt_detect_reset_en: `PMSC_RST_DET_RST_EN,
        irq_stat: `PMSC_RST_IRQ,
        irq_en: `PMSC_RST_IRQ,
        rdata: `PMSC_RST_BYTE,
        default: `PMSC_RST_BIT
    };

    pmsc_state_s st_r;
    pmsc_state_s st_nxt;

    // one write hit on a given register offset
    function automatic logic wr_hit(
        input logic strobe,
        input pmsc_addr_t a,
        input pmsc_addr_t ofs
    );
        wr_hit = strobe && (a == ofs);
    endfunction

    // first register image as software sees it
    function automatic pmsc_byte_t ctrl1_image(input pmsc_state_s s);
        pmsc_byte_t v;
        v = `PMSC_RST_BYTE;
        v[`PMSC_C1_DET_FLAG] = s.low_volt_detect_flag;
        v[`PMSC_C1_DET_IRQ_EN] = s.low_volt_detect_irq_en;
        v[`PMSC_C1_SAFE_STATE] = s.safe_state;
        v[`PMSC_C1_DET_RST_EN] = s.low_volt_detect_reset_en;
        ctrl1_image = v;
    endfunction

    // second register image; ack bits and unused bits stay zero
    function automatic pmsc_byte_t ctrl2_image(input pmsc_state_s s);
        pmsc_byte_t v;
        v = `PMSC_RST_BYTE;
        v[`PMSC_C2_WARN_FLAG] = s.low_volt_warning_flag;
        v[`PMSC_C2_PPD_FLAG] = s.partial_powerdown_flag;
        v[`PMSC_C2_PD_EN] = s.powerdown_enable;
        v[`PMSC_C2_PPD_SEL] = s.partial_powerdown_select;
        ctrl2_image = v;
    endfunction

    always_comb begin
        logic wr_c1;
        logic wr_c2;
        logic wr_clr;
        logic wr_en;
        logic det_set;
        logic warn_set;
        logic ppd_set;
        logic det_ack;
        logic warn_ack;
        logic ppd_ack;
        pmsc_irq_t events;
        pmsc_byte_t rd_mux;

        wr_c1 = wr_hit(wr, addr, `PMSC_OFS_CTRL1);
        wr_c2 = wr_hit(wr, addr, `PMSC_OFS_CTRL2);
        wr_clr = wr_hit(wr, addr, `PMSC_OFS_IRQ_CLR);
        wr_en = wr_hit(wr, addr, `PMSC_OFS_IRQ_EN);
        det_set = 1'b0;
        warn_set = 1'b0;
        ppd_set = 1'b0;
        det_ack = 1'b0;
        warn_ack = 1'b0;
        ppd_ack = 1'b0;
        events = `PMSC_RST_IRQ;
        rd_mux = `PMSC_RST_BYTE;

        st_nxt = st_r;

        // comparator and recovery pins are asynchronous: two stages first
        st_nxt.det_s1 = det_trip;
        st_nxt.det_s2 = st_r.det_s1;
        st_nxt.warn_s1 = warn_trip;
        st_nxt.warn_s2 = st_r.warn_s1;
        st_nxt.rearm_s1 = below_rearm;
        st_nxt.rearm_s2 = st_r.rearm_s1;
        st_nxt.ppd_s1 = ppd_recovered;
        st_nxt.ppd_s2 = st_r.ppd_s1;
        st_nxt.ppd_s3 = st_r.ppd_s2;

        // hardware set terms; all take priority over a same-cycle ack
        det_set = low_volt_detect_en && st_r.det_s2;
        // a level, so a supply already low after reset sets it too
        warn_set = st_r.warn_s2;
        ppd_set = st_r.ppd_s2 && !st_r.ppd_s3;

        det_ack = wr_c1 && wdata[`PMSC_C1_DET_ACK];
        warn_ack = wr_c2 && wdata[`PMSC_C2_WARN_ACK];
        ppd_ack = wr_c2 && wdata[`PMSC_C2_PPD_ACK];

        // detect flag: read-only, cleared by writing one to its ack
        if (det_set) begin
            st_nxt.low_volt_detect_flag = 1'b1;
        end else if (det_ack) begin
            st_nxt.low_volt_detect_flag = 1'b0;
        end

        // warning flag: ack is refused while the warning is present
        if (warn_set) begin
            st_nxt.low_volt_warning_flag = 1'b1;
        end else if (warn_ack) begin
            st_nxt.low_volt_warning_flag = 1'b0;
        end

        if (ppd_set) begin
            st_nxt.partial_powerdown_flag = 1'b1;
        end else if (ppd_ack) begin
            st_nxt.partial_powerdown_flag = 1'b0;
        end

        // plain read/write fields of the first register
        if (wr_c1) begin
            st_nxt.low_volt_detect_irq_en = wdata[`PMSC_C1_DET_IRQ_EN];
            st_nxt.safe_state = wdata[`PMSC_C1_SAFE_STATE];
        end

        // reset enable takes only the first write to its register after each reset; sys_reset reopens it but keeps the value
        if (wr_c1 && !st_r.det_rst_en_locked) begin
            st_nxt.low_volt_detect_reset_en = wdata[`PMSC_C1_DET_RST_EN];
            st_nxt.det_rst_en_locked = 1'b1;
        end

        // both stop-mode selects lock on the first write together
        if (wr_c2 && !st_r.pd_locked) begin
            st_nxt.powerdown_enable = wdata[`PMSC_C2_PD_EN];
            st_nxt.partial_powerdown_select = wdata[`PMSC_C2_PPD_SEL];
            st_nxt.pd_locked = 1'b1;
        end

        // interrupt status: new flag rising edges are the events
        events[`PMSC_IRQ_DET] = det_set && !st_r.low_volt_detect_flag;
        events[`PMSC_IRQ_WARN] = warn_set && !st_r.low_volt_warning_flag;
        events[`PMSC_IRQ_PPD] = ppd_set && !st_r.partial_powerdown_flag;

        if (wr_clr) begin
            st_nxt.irq_stat = st_r.irq_stat & ~wdata[`PMSC_IRQ_W-1:0];
        end
        // set wins over a clear in the same cycle
        st_nxt.irq_stat = st_nxt.irq_stat | events;

        if (wr_en) begin
            st_nxt.irq_en = wdata[`PMSC_IRQ_W-1:0];
        end

        // read data stand one cycle after the strobe, zero otherwise
        unique case (addr)
            `PMSC_OFS_CTRL1: rd_mux = ctrl1_image(st_r);
            `PMSC_OFS_CTRL2: rd_mux = ctrl2_image(st_r);
            `PMSC_OFS_IRQ_STAT: begin
                rd_mux = {{(`PMSC_DATA_W-`PMSC_IRQ_W){1'b0}}, st_r.irq_stat};
            end
            `PMSC_OFS_IRQ_EN: begin
                rd_mux = {{(`PMSC_DATA_W-`PMSC_IRQ_W){1'b0}}, st_r.irq_en};
            end
            default: rd_mux = `PMSC_RST_BYTE;
        endcase
        st_nxt.rdata = rd ? rd_mux : `PMSC_RST_BYTE;

        // outputs registered from the next state so they track flags
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);
        st_nxt.det_irq_req = st_nxt.low_volt_detect_irq_en &&
            st_nxt.low_volt_detect_flag;
        st_nxt.det_rst_req = st_nxt.low_volt_detect_reset_en &&
            st_nxt.low_volt_detect_flag;
        st_nxt.wake_block = st_nxt.safe_state && st_r.rearm_s2;

        // other resets clear all but the power-on-only reset enable
        if (sys_reset) begin
            st_nxt = ST_RST;
            st_nxt.low_volt_detect_reset_en =
                st_r.low_volt_detect_reset_en;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign irq = st_r.irq;
    assign det_irq_req = st_r.det_irq_req;
    assign det_rst_req = st_r.det_rst_req;
    assign wake_block = st_r.wake_block;
    // zero keeps both power-down stop modes out of reach
    assign powerdown_enable = st_r.powerdown_enable;
    assign partial_powerdown_select = st_r.partial_powerdown_select;

endmodule // pmsc_top

`default_nettype wire

// *** pmsc_top_asserts.sv ***
// concurrent checks on the ports of the power management block
`include "pmsc_map.svh"
`timescale 1ns/1ns
`default_nettype none

module pmsc_top_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sys_reset,
    input wire logic det_trip,
    input wire logic below_rearm,
    input wire logic [`PMSC_ADDR_W-1:0] addr,
    input wire logic [`PMSC_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [`PMSC_DATA_W-1:0] rdata,
    input wire logic det_irq_req,
    input wire logic det_rst_req,
    input wire logic wake_block,
    input wire logic powerdown_enable,
    input wire logic partial_powerdown_select
);
    logic c2_seen_r;
    logic [1:0] pd_wr;
    assign pd_wr = wdata[1:0];
    // lock tracker, cleared by either reset like the design's own lock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) c2_seen_r <= 1'b0;
        else c2_seen_r <= !sys_reset && (c2_seen_r ||
            (wr && addr == `PMSC_OFS_CTRL2));
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst || sys_reset);

    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_ack_rd_zero: assert property ($past(rd) &&
        $past(addr) == `PMSC_OFS_CTRL1 |-> !rdata[`PMSC_C1_DET_ACK])
        else $error("detect ack bit reads one");
    chk_c2_resv_zero: assert property ($past(rd) &&
        $past(addr) == `PMSC_OFS_CTRL2 |-> rdata[5:4] == 2'h0)
        else $error("reserved bits read nonzero");
    chk_pd_first_wr: assert property (wr &&
        addr == `PMSC_OFS_CTRL2 && !c2_seen_r |=>
        {powerdown_enable, partial_powerdown_select} == $past(pd_wr))
        else $error("first power-down write not taken");
    chk_pd_locked: assert property (c2_seen_r |=>
        $stable(powerdown_enable) && $stable(partial_powerdown_select))
        else $error("write-once power-down bits changed");
    chk_det_rst_rise: assert property ($rose(det_rst_req) |->
        $past(det_trip, 3))
        else $error("reset request without detect event");
    chk_det_irq_hold: assert property ($fell(det_irq_req) |->
        $past(wr) || $past(sys_reset))
        else $error("detect irq request dropped by itself");
    chk_wake_follow: assert property (wake_block |->
        $past(below_rearm, 3))
        else $error("wake block without low supply");

    cover property (det_rst_req);
    cover property (wake_block);
    cover property (powerdown_enable && partial_powerdown_select);
endmodule // pmsc_top_asserts

bind pmsc_top pmsc_top_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
    .sys_reset(sys_reset), .det_trip(det_trip), .below_rearm(below_rearm),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .det_irq_req(det_irq_req), .det_rst_req(det_rst_req),
    .wake_block(wake_block), .powerdown_enable(powerdown_enable),
    .partial_powerdown_select(partial_powerdown_select));

`default_nettype wire

// *** pmsc_top_bench.sv ***
// self-checking bench for the power management status block
`include "pmsc_map.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module pmsc_top_bench;
    logic clk_sys = 1'b0;
    logic rst, sys_reset, low_volt_detect_en, det_trip, warn_trip;
    logic below_rearm, ppd_recovered, wr, rd;
    logic [`PMSC_ADDR_W-1:0] addr;
    logic [`PMSC_DATA_W-1:0] wdata, rdata;
    logic irq, det_irq_req, det_rst_req, wake_block;
    logic powerdown_enable, partial_powerdown_select;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;

    pmsc_top uut (.clk_sys(clk_sys), .rst(rst), .sys_reset(sys_reset),
        .low_volt_detect_en(low_volt_detect_en), .det_trip(det_trip),
        .warn_trip(warn_trip), .below_rearm(below_rearm),
        .ppd_recovered(ppd_recovered), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .det_irq_req(det_irq_req), .det_rst_req(det_rst_req),
        .wake_block(wake_block), .powerdown_enable(powerdown_enable),
        .partial_powerdown_select(partial_powerdown_select));

    always #2 clk_sys = ~clk_sys;

    task automatic tally_and_finish;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // a hang costs one mismatch, then the normal report
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            tally_and_finish;
        end
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        wait_cyc(1);
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask

    task automatic t_reset_vals;
        rd_chk(`PMSC_OFS_CTRL1, 8'h08);
        rd_chk(`PMSC_OFS_CTRL2, 8'h00);
        rd_chk(3'h7, 8'h00);
    endtask

    task automatic t_detect;
        @(posedge clk_sys);
        low_volt_detect_en <= 1'b1;
        det_trip <= 1'b1;
        wait_cyc(5);
        `CHK({det_rst_req, det_irq_req, irq}, 3'b100)
        rd_chk(`PMSC_OFS_CTRL1, 8'h88);
        // ack while the trip persists must not clear the flag
        bus_wr(`PMSC_OFS_CTRL1, 8'h60);
        `CHK({det_irq_req, det_rst_req}, 2'b10)
        bus_wr(`PMSC_OFS_IRQ_EN, 8'h01);
        `CHK(irq, 1'b1)
        @(posedge clk_sys);
        det_trip <= 1'b0;
        wait_cyc(5);
        bus_wr(`PMSC_OFS_CTRL1, 8'h68);
        rd_chk(`PMSC_OFS_CTRL1, 8'h20);
        `CHK(det_irq_req, 1'b0)
        bus_wr(`PMSC_OFS_IRQ_CLR, 8'h01);
        `CHK(irq, 1'b0)
    endtask

    task automatic t_warn;
        @(posedge clk_sys);
        warn_trip <= 1'b1;
        wait_cyc(5);
        rd_chk(`PMSC_OFS_CTRL2, 8'h80);
        bus_wr(`PMSC_OFS_CTRL2, 8'h43);
        `CHK({powerdown_enable, partial_powerdown_select}, 2'b11)
        rd_chk(`PMSC_OFS_CTRL2, 8'h83);
        @(posedge clk_sys);
        warn_trip <= 1'b0;
        wait_cyc(5);
        rd_chk(`PMSC_OFS_CTRL2, 8'h83);
        bus_wr(`PMSC_OFS_CTRL2, 8'h70);
        rd_chk(`PMSC_OFS_CTRL2, 8'h03);
    endtask

    task automatic t_ppd;
        @(posedge clk_sys);
        ppd_recovered <= 1'b1;
        wait_cyc(5);
        rd_chk(`PMSC_OFS_CTRL2, 8'h0b);
        @(posedge clk_sys);
        ppd_recovered <= 1'b0;
        bus_wr(`PMSC_OFS_CTRL2, 8'h04);
        rd_chk(`PMSC_OFS_CTRL2, 8'h03);
    endtask

    task automatic t_other_reset;
        @(posedge clk_sys);
        sys_reset <= 1'b1;
        @(posedge clk_sys);
        sys_reset <= 1'b0;
        wait_cyc(1);
        rd_chk(`PMSC_OFS_CTRL1, 8'h00);
        `CHK(powerdown_enable, 1'b0)
        bus_wr(`PMSC_OFS_CTRL1, 8'h10);
        @(posedge clk_sys);
        below_rearm <= 1'b1;
        wait_cyc(5);
        `CHK(wake_block, 1'b1)
        @(posedge clk_sys);
        below_rearm <= 1'b0;
        wait_cyc(5);
        `CHK(wake_block, 1'b0)
    endtask

    initial begin
        {rst, sys_reset, low_volt_detect_en, det_trip} <= 4'hf - 4'h7;
        {warn_trip, below_rearm, ppd_recovered, wr, rd} <= 5'h00;
        addr <= 3'h0;
        wdata <= 8'h00;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_vals;
        t_detect;
        t_warn;
        t_ppd;
        t_other_reset;
        tally_and_finish;
    end
endmodule // pmsc_top_bench

`default_nettype wire
